// ===== logic/hsl_pkg.sv
package hsl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CUSTOM_REF_HZ = 26_000_000;
    localparam int GAP_STEP_US = 200;
    localparam int TEST_GAP_MS = 3;
    localparam int RESET_MIN_NS = 250;
    localparam int GAP_STEP_CYC = GAP_STEP_US * (CLK_HZ / 1_000_000);
    localparam int TEST_GAP_CYC = TEST_GAP_MS * (CLK_HZ / 1_000);
    localparam int AUTO_GAP_NUM = 100_000;
    localparam logic [63:0] CUST_K = ((64'h1 << 28) * 64'(CLK_HZ)) / 64'(CUSTOM_REF_HZ);
    localparam logic [7:0] REG_BAUD = 8'h42;
    localparam logic [7:0] REG_BAUD_M = 8'h43;
    localparam logic [7:0] REG_BAUD_E = 8'h44;
    localparam logic [7:0] REG_GAP = 8'h58;
    localparam logic [7:0] REG_PKT = 8'h5a;
    localparam logic [7:0] REG_CTS_ON = 8'h5c;
    localparam logic [7:0] REG_CTS_OFF = 8'h5e;
    localparam logic [7:0] BAUD_TEST_CODE = 8'h03;
    localparam logic [7:0] BAUD_MAX_CODE = 8'h0a;
    localparam logic [7:0] BAUD_CUSTOM = 8'he3;
    localparam logic [7:0] GAP_MIN = 8'h02;
    localparam logic [7:0] BAUD_SEL_RST = 8'h09;
    localparam logic [7:0] GAP_RST = 8'h02;
    localparam logic [7:0] PKT_RST = 8'h60;
    localparam logic [7:0] CTS_ON_RST = 8'hc0;
    localparam logic [7:0] CTS_OFF_RST = 8'h80;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam int BAUD_TAB [0:10] = '{1200, 2400, 4800, 9600, 14400, 19200, 28800,
        38400, 57600, 115200, 230400};
    localparam logic [7:0] GAP_TAB [0:10] = '{8'h53, 8'h2a, 8'h15, 8'h10, 8'h07, 8'h05,
        8'h03, 8'h02, 8'h02, 8'h02, 8'h02};

    typedef enum logic [1:0] {rx_idle, rx_start, rx_bits, rx_stop} hsl_rx_state_t;
    typedef enum logic [1:0] {tx_idle, tx_start, tx_bits, tx_stop} hsl_tx_state_t;

    // Clock cycles per bit: nearest-rounded for table codes, truncated for the custom code.
    function automatic logic [15:0] hsl_baud_div(input logic [7:0] code,
        input logic [7:0] m, input logic [7:0] e);
        logic [63:0] q;
        logic [63:0] d;
        int b;
        b = BAUD_TAB[3];
        if (code <= BAUD_MAX_CODE) begin
            b = BAUD_TAB[code[3:0]];
        end
        q = (64'(CLK_HZ) + 64'(b / 2)) / 64'(b);
        if (code == BAUD_CUSTOM) begin
            d = {55'h0, 1'b1, m} << e[4:0];
            q = CUST_K / d;
        end
        if (q > 64'hffff) begin
            q = 64'hffff;
        end
        if (q < 64'h2) begin
            q = 64'h2;
        end
        return q[15:0];
    endfunction : hsl_baud_div

    function automatic logic [7:0] hsl_auto_gap(input logic [7:0] code,
        input logic [15:0] div);
        logic [63:0] g;
        g = (64'(AUTO_GAP_NUM) * 64'(div)) / 64'(CLK_HZ);
        if (code <= BAUD_MAX_CODE) begin
            g = 64'(GAP_TAB[code[3:0]]);
        end
        if (g > 64'hff) begin
            g = 64'hff;
        end
        if (g < 64'(GAP_MIN)) begin
            g = 64'(GAP_MIN);
        end
        return g[7:0];
    endfunction : hsl_auto_gap

    localparam logic [15:0] BAUD_DIV_RST = hsl_baud_div(BAUD_SEL_RST, 8'h00, 8'h00);
    localparam logic [15:0] TEST_DIV = hsl_baud_div(BAUD_TEST_CODE, 8'h00, 8'h00);
endpackage : hsl_pkg

// ===== logic/hsl_uart_rx.sv
`timescale 1ns/10ps
module hsl_uart_rx
    import hsl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic rxd,
    input wire logic [15:0] div,
    output logic [7:0] data,
    output logic valid,
    output logic busy
);
    hsl_rx_state_t state;
    logic rxd_meta;
    logic rxd_s;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rxd_meta <= 1'b1;
            rxd_s <= 1'b1;
        end else begin
            rxd_meta <= rxd;
            rxd_s <= rxd_meta;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= rx_idle;
            cnt <= 16'h0;
            bitn <= 3'h0;
            shift <= 8'h0;
            data <= 8'h0;
            valid <= 1'b0;
        end else begin
            valid <= 1'b0;
            case (state)
                rx_idle: if (!rxd_s) begin
                    state <= rx_start;
                    cnt <= {1'b0, div[15:1]};
                end
                rx_start: if (cnt == 16'h0) begin
                    state <= rxd_s ? rx_idle : rx_bits;
                    cnt <= div - 16'h1;
                    bitn <= 3'h0;
                end else begin
                    cnt <= cnt - 16'h1;
                end
                rx_bits: if (cnt == 16'h0) begin
                    shift <= {rxd_s, shift[7:1]};
                    cnt <= div - 16'h1;
                    bitn <= bitn + 3'h1;
                    if (bitn == 3'h7) begin
                        state <= rx_stop;
                    end
                end else begin
                    cnt <= cnt - 16'h1;
                end
                rx_stop: if (cnt == 16'h0) begin
                    state <= rx_idle;
                    data <= shift;
                    valid <= rxd_s;
                end else begin
                    cnt <= cnt - 16'h1;
                end
                default: state <= rx_idle;
            endcase
        end
    end

    assign busy = state != rx_idle;
endmodule : hsl_uart_rx

// ===== logic/hsl_uart_tx.sv
`timescale 1ns/10ps
module hsl_uart_tx
    import hsl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [15:0] div,
    input wire logic start,
    input wire logic [7:0] data,
    output logic txd,
    output logic busy
);
    hsl_tx_state_t state;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= tx_idle;
            cnt <= 16'h0;
            bitn <= 3'h0;
            shift <= 8'h0;
            txd <= 1'b1;
        end else begin
            case (state)
                tx_idle: if (start) begin
                    shift <= data;
                    txd <= 1'b0;
                    cnt <= div - 16'h1;
                    state <= tx_start;
                end
                tx_start: if (cnt == 16'h0) begin
                    txd <= shift[0];
                    shift <= shift >> 1;
                    bitn <= 3'h0;
                    cnt <= div - 16'h1;
                    state <= tx_bits;
                end else begin
                    cnt <= cnt - 16'h1;
                end
                tx_bits: if (cnt == 16'h0) begin
                    cnt <= div - 16'h1;
                    bitn <= bitn + 3'h1;
                    txd <= (bitn == 3'h7) ? 1'b1 : shift[0];
                    shift <= shift >> 1;
                    if (bitn == 3'h7) begin
                        state <= tx_stop;
                    end
                end else begin
                    cnt <= cnt - 16'h1;
                end
                tx_stop: if (cnt == 16'h0) begin
                    state <= tx_idle;
                end else begin
                    cnt <= cnt - 16'h1;
                end
                default: state <= tx_idle;
            endcase
        end
    end

    assign busy = state != tx_idle;
endmodule : hsl_uart_tx

// ===== logic/hsl_frontend.sv
`timescale 1ns/10ps
// Behaviour
// R1: Strap low at reset forces 9600 8-N-1.
// R2: Test mode uses fixed 3 ms gap.
// R3: Test mode uses rate default packet size.
// R4: Test mode left only by reset.
// R5: Host holds reset at least 250 ns.
// R6: Select high makes host bytes payload.
// R7: Select low: commands, no outgoing packets.
// R8: Forward-disable drops radio data in command mode.
// R9: Client shows sync low, else high.
// R10: Server holds in-range output low.
// R11: RTS off: send to host at once.
// R12: RTS on and high: hold host data.
// R13: CTS follows host-input buffer fill.
// R14: Host stops sending while CTS high.
// R15: Release block on size or gap.
// R16: Command mode from pin or string.
// R17: Baud from stored code or custom.
// R18: Gap in 200 us steps, auto minimum.
// R19: Rates agree within three percent.
// R20: Gap overrun closes current block.
// R21: CTS thresholds on and off.
// R22: Up to two bytes after RTS stop.
// R23: Sync pins, mode change at byte boundary.
module hsl_frontend
    import hsl_pkg::*;
#(
    parameter int HB_AW = 8,
    parameter int OB_AW = 6,
    parameter int GAP_STEP = GAP_STEP_CYC,
    parameter int TEST_GAP = TEST_GAP_CYC,
    parameter logic [7:0] TEST_PKT_FAST = 8'hef,
    parameter logic [7:0] TEST_PKT_SLOW = 8'h60
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rxd,
    output logic txd,
    input wire logic test_strap_n,
    input wire logic cmd_data_sel,
    input wire logic rts_n,
    output logic cts_n,
    output logic in_range_n,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic auto_config,
    input wire logic rts_mode,
    input wire logic rx_fwd_disable,
    input wire logic server_role,
    input wire logic link_synced,
    input wire logic rf_rate_fast,
    input wire logic at_cmd_mode,
    input wire logic pkt_pop,
    output logic [7:0] pkt_data,
    output logic pkt_data_valid,
    output logic pkt_done,
    output logic [7:0] pkt_len,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic cmd_end,
    input wire logic [7:0] fwd_data,
    input wire logic fwd_valid,
    output logic fwd_ready,
    output logic test_mode,
    output logic cmd_mode
);
    localparam int HB_DEPTH = 2 ** HB_AW;
    localparam int OB_DEPTH = 2 ** OB_AW;

    logic [2:0] pin_meta;
    logic [2:0] pin_s;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [7:0] baud_sel;
    logic [7:0] baud_m;
    logic [7:0] baud_e;
    logic [7:0] gap_reg;
    logic [7:0] pkt_size;
    logic [7:0] cts_on;
    logic [7:0] cts_off;
    logic [7:0] baud_code;
    logic [15:0] baud_div;
    logic [7:0] gap_steps;
    logic [31:0] gap_lim;
    logic [7:0] size_lim;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_busy;
    logic tx_busy;
    logic tx_go;
    logic [7:0] tx_data;
    logic [7:0] hbuf [0:HB_DEPTH-1];
    logic [HB_AW-1:0] wptr;
    logic [HB_AW-1:0] rptr;
    logic [HB_AW:0] hcount;
    logic [HB_AW:0] rel_left;
    logic [7:0] open_cnt;
    logic [31:0] idle_cyc;
    logic blk_cmd;
    logic room;
    logic take;
    logic push;
    logic pop;
    logic blk_close;
    logic [7:0] obuf [0:OB_DEPTH-1];
    logic [OB_AW-1:0] owptr;
    logic [OB_AW-1:0] orptr;
    logic [OB_AW:0] ocount;
    logic [OB_AW:0] next_ocount;
    logic fwd_take;
    logic fwd_drop;
    logic opush;
    logic send;

    // Bit 0 strap, bit 1 command/data select, bit 2 RTS.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_meta <= 3'h7;
            pin_s <= 3'h7;
        end else begin
            pin_meta <= {rts_n, cmd_data_sel, test_strap_n}; // R23
            pin_s <= pin_meta;
        end
    end

    // Strap is caught once, after the synchroniser has settled.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            test_mode <= 1'b0;
        end else if (!strap_done) begin
            if (strap_wait == STRAP_WAIT) begin
                test_mode <= !pin_s[0]; // R1
                strap_done <= 1'b1; // R4
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            baud_sel <= BAUD_SEL_RST;
            baud_m <= 8'h00;
            baud_e <= 8'h00;
            gap_reg <= GAP_RST;
            pkt_size <= PKT_RST;
            cts_on <= CTS_ON_RST;
            cts_off <= CTS_OFF_RST;
        end else if (cfg_we) begin
            case (cfg_addr)
                REG_BAUD: baud_sel <= cfg_wdata;
                REG_BAUD_M: baud_m <= cfg_wdata;
                REG_BAUD_E: baud_e <= cfg_wdata;
                REG_GAP: gap_reg <= cfg_wdata;
                REG_PKT: pkt_size <= cfg_wdata;
                REG_CTS_ON: cts_on <= cfg_wdata;
                REG_CTS_OFF: cts_off <= cfg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_rdata <= 8'h00;
        end else begin
            case (cfg_addr)
                REG_BAUD: cfg_rdata <= baud_sel;
                REG_BAUD_M: cfg_rdata <= baud_m;
                REG_BAUD_E: cfg_rdata <= baud_e;
                REG_GAP: cfg_rdata <= gap_reg;
                REG_PKT: cfg_rdata <= pkt_size;
                REG_CTS_ON: cfg_rdata <= cts_on;
                REG_CTS_OFF: cfg_rdata <= cts_off;
                default: cfg_rdata <= 8'h00;
            endcase
        end
    end

    always_comb begin
        baud_code = test_mode ? BAUD_TEST_CODE : baud_sel; // R1
        gap_steps = auto_config ? hsl_auto_gap(baud_code, baud_div) : gap_reg; // R18
        gap_lim = test_mode ? 32'(TEST_GAP) : 32'(gap_steps) * 32'(GAP_STEP); // R2
        size_lim = pkt_size;
        if (test_mode) begin
            size_lim = rf_rate_fast ? TEST_PKT_FAST : TEST_PKT_SLOW; // R3
        end
    end

    // Divisor is nearest-rounded for table codes and truncated for the custom code.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            baud_div <= BAUD_DIV_RST;
        end else begin
            baud_div <= hsl_baud_div(baud_code, baud_m, baud_e); // R17 R19
        end
    end

    // Mode only moves while the receiver sits between bytes.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cmd_mode <= 1'b0;
        end else if (!rx_busy && !rx_valid) begin
            cmd_mode <= !pin_s[1] || at_cmd_mode; // R16 R23
        end
    end

    hsl_uart_rx u_rx (
        .mclk(mclk),
        .reset(reset),
        .rxd(rxd),
        .div(baud_div),
        .data(rx_data),
        .valid(rx_valid),
        .busy(rx_busy)
    );

    hsl_uart_tx u_tx (
        .mclk(mclk),
        .reset(reset),
        .div(baud_div),
        .start(tx_go),
        .data(tx_data),
        .txd(txd),
        .busy(tx_busy)
    );

    // A byte arriving at a full buffer is lost; the host must respect CTS.
    assign room = hcount != (HB_AW + 1)'(HB_DEPTH); // R14
    assign take = rx_valid && (cmd_mode || room);
    assign push = rx_valid && !cmd_mode && room; // R6 R7
    assign pop = pkt_pop && rel_left != '0;
    assign blk_close = open_cnt != 8'h0 && (open_cnt >= size_lim || idle_cyc >= gap_lim); // R15 R20

    always_ff @(posedge mclk) begin
        if (push) begin
            hbuf[wptr] <= rx_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wptr <= '0;
            rptr <= '0;
            hcount <= '0;
            rel_left <= '0;
            pkt_data <= 8'h00;
            pkt_data_valid <= 1'b0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
                pkt_data <= hbuf[rptr];
            end
            pkt_data_valid <= pop;
            hcount <= hcount + (HB_AW + 1)'(push) - (HB_AW + 1)'(pop);
            rel_left <= rel_left - (HB_AW + 1)'(pop)
                + ((blk_close && !blk_cmd) ? (HB_AW + 1)'(open_cnt) : '0); // R15
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            open_cnt <= 8'h00;
            idle_cyc <= 32'h0;
            blk_cmd <= 1'b0;
            pkt_done <= 1'b0;
            pkt_len <= 8'h00;
            cmd_end <= 1'b0;
        end else begin
            open_cnt <= (blk_close ? 8'h00 : open_cnt) + 8'(take);
            if (take) begin
                idle_cyc <= 32'h0;
            end else if (open_cnt != 8'h0 && idle_cyc != 32'hffffffff) begin
                idle_cyc <= idle_cyc + 32'h1; // R18
            end
            if (take && (open_cnt == 8'h0 || blk_close)) begin
                blk_cmd <= cmd_mode;
            end
            pkt_done <= blk_close && !blk_cmd; // R15
            cmd_end <= blk_close && blk_cmd;
            if (blk_close) begin
                pkt_len <= open_cnt;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cmd_valid <= 1'b0;
            cmd_byte <= 8'h00;
        end else begin
            cmd_valid <= rx_valid && cmd_mode; // R7
            if (rx_valid && cmd_mode) begin
                cmd_byte <= rx_data;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cts_n <= 1'b0;
        end else if (hcount >= (HB_AW + 1)'(cts_on)) begin
            cts_n <= 1'b1; // R13 R21
        end else if (hcount <= (HB_AW + 1)'(cts_off)) begin
            cts_n <= 1'b0; // R13 R21
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            in_range_n <= 1'b0;
        end else begin
            in_range_n <= !server_role && !link_synced; // R9 R10
        end
    end

    // Radio data towards the host.
    assign fwd_take = fwd_valid && fwd_ready;
    assign fwd_drop = rx_fwd_disable && cmd_mode; // R8
    assign opush = fwd_take && !fwd_drop;
    // RTS is checked only at a byte start, so one more byte may still go out.
    assign send = !tx_busy && !tx_go && ocount != '0 && !(rts_mode && pin_s[2]); // R11 R12 R22
    assign next_ocount = ocount + (OB_AW + 1)'(opush) - (OB_AW + 1)'(send);

    always_ff @(posedge mclk) begin
        if (opush) begin
            obuf[owptr] <= fwd_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            owptr <= '0;
            orptr <= '0;
            ocount <= '0;
            tx_go <= 1'b0;
            tx_data <= 8'h00;
            fwd_ready <= 1'b1;
        end else begin
            if (opush) begin
                owptr <= owptr + 1'b1;
            end
            if (send) begin
                orptr <= orptr + 1'b1;
                tx_data <= obuf[orptr];
            end
            tx_go <= send;
            ocount <= next_ocount;
            fwd_ready <= next_ocount != (OB_AW + 1)'(OB_DEPTH);
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence strap_seen_s;
        !strap_done ##1 strap_done;
    endsequence

    sequence gap_over_s;
        open_cnt != 8'h0 && !take && idle_cyc >= gap_lim;
    endsequence

    strap_catch_a: // R1
    assert property (strap_seen_s |-> test_mode == !$past(pin_s[0]))
        else $error("test mode does not match strap");
    test_baud_a: // R1
    assert property (test_mode && $past(test_mode, 2) |-> baud_div == TEST_DIV)
        else $error("test mode baud divisor wrong");
    test_gap_a: // R2 R3
    assert property (test_mode |-> gap_lim == 32'(TEST_GAP)
        && size_lim == (rf_rate_fast ? TEST_PKT_FAST : TEST_PKT_SLOW))
        else $error("test mode gap limit wrong");
    strap_hold_a: // R4
    assert property ($past(strap_done) |-> $stable(test_mode))
        else $error("test mode changed without reset");
    cmd_no_push_a: // R7
    assert property (rx_valid && cmd_mode |=> cmd_valid && hcount <= $past(hcount))
        else $error("command byte entered payload buffer");
    data_push_a: // R6
    assert property (rx_valid && !cmd_mode && room && !pop |=> hcount == $past(hcount) + 1'b1)
        else $error("payload byte not buffered");
    fwd_drop_a: // R8
    assert property (fwd_take && fwd_drop && !send |=> ocount == $past(ocount))
        else $error("radio data forwarded in command mode");
    range_out_a: // R9 R10
    assert property (1'b1 |=> in_range_n == (!$past(server_role) && !$past(link_synced)))
        else $error("in-range output wrong");
    rts_hold_a: // R12
    assert property (rts_mode && pin_s[2] |=> !tx_go)
        else $error("byte started while host holds RTS");
    rts_free_a: // R11
    assert property (!rts_mode && ocount != '0 && !tx_busy && !tx_go |=> tx_go)
        else $error("pending byte not sent");
    cts_raise_a: // R21
    assert property (hcount >= (HB_AW + 1)'(cts_on) |=> cts_n)
        else $error("CTS not raised at threshold");
    gap_close_a: // R20
    assert property (gap_over_s |=> (pkt_done || cmd_end) && open_cnt == 8'h0)
        else $error("gap overrun did not close block");
endmodule : hsl_frontend

// ===== sim/hsl_host_model.sv
`timescale 1ns/10ps
module hsl_host_model #(
    parameter int BIT_NS = 4350
) (
    output logic rxd,
    input wire logic txd,
    input wire logic cts_n
);
    logic [7:0] got [$];
    logic [7:0] sh;
    initial begin
        rxd = 1'b1;
    end
    // Sends one 8-N-1 frame, LSB first, holding off while the device asks it to stop.
    task automatic send(input logic [7:0] b);
        wait (cts_n === 1'b0);
        rxd = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            #(BIT_NS);
        end
        rxd = 1'b1;
        #(BIT_NS);
    endtask : send
    // Collects frames from the device, sampled at mid-bit.
    always begin
        @(negedge txd);
        #(BIT_NS / 2);
        for (int i = 0; i < 8; i++) begin
            #(BIT_NS);
            sh[i] = txd;
        end
        #(BIT_NS);
        if (txd === 1'b1) begin
            got.push_back(sh);
        end
    end
endmodule : hsl_host_model

// ===== sim/hsl_frontend_tb.sv
`timescale 1ns/10ps
module hsl_frontend_tb import hsl_pkg::*; ;
    logic mclk = 1'b0, reset = 1'b1, test_strap_n = 1'b1, cmd_data_sel = 1'b1, rts_n = 1'b0;
    logic cfg_we = 1'b0, auto_config = 1'b0, rts_mode = 1'b0, rx_fwd_disable = 1'b0;
    logic server_role = 1'b0, link_synced = 1'b0, rf_rate_fast = 1'b0, at_cmd_mode = 1'b0;
    logic pkt_pop = 1'b0, fwd_valid = 1'b0, rxd;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, fwd_data = 8'h00;
    logic txd, cts_n, in_range_n, pkt_data_valid, pkt_done, cmd_valid, cmd_end;
    logic fwd_ready, test_mode, cmd_mode;
    logic [7:0] cfg_rdata, pkt_data, pkt_len, cmd_byte;
    logic [7:0] q [4];
    logic [7:0] popq [$];
    logic [7:0] cmdq [$];
    int bad_count = 0, num_checks = 0, cyc = 0, n_done = 0, w;
    localparam logic [7:0] RA [7] = '{REG_BAUD, REG_BAUD_M, REG_BAUD_E, REG_GAP, REG_PKT,
        REG_CTS_ON, REG_CTS_OFF};
    localparam logic [7:0] RV [7] = '{8'h09, 8'h00, 8'h00, 8'h02, 8'h60, 8'hc0, 8'h80};
    hsl_frontend #(.GAP_STEP(8), .TEST_GAP(40)) dut (.mclk, .reset, .rxd, .txd, .test_strap_n,
        .cmd_data_sel, .rts_n, .cts_n, .in_range_n, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .auto_config, .rts_mode, .rx_fwd_disable, .server_role, .link_synced, .rf_rate_fast,
        .at_cmd_mode, .pkt_pop, .pkt_data, .pkt_data_valid, .pkt_done, .pkt_len, .cmd_byte,
        .cmd_valid, .cmd_end, .fwd_data, .fwd_valid, .fwd_ready, .test_mode, .cmd_mode);
    hsl_host_model #(.BIT_NS(4350)) host (.rxd, .txd, .cts_n);
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        n_done <= n_done + int'(pkt_done === 1'b1);
        if (pkt_data_valid === 1'b1) popq.push_back(pkt_data);
        if (cmd_valid === 1'b1) cmdq.push_back(cmd_byte);
        if (cyc == 90000) begin
            bad_count++;
            conclude();
        end
    end
    function automatic int start_cycles(input int baud);
        return (CLK_HZ + baud / 2) / baud;
    endfunction : start_cycles
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask : ticks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {cfg_we, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge mclk);
        cfg_we = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        cfg_addr = a;
        ticks(2);
        chk("reg", 16'(cfg_rdata), 16'(exp));
    endtask : rd
    task automatic pop(input int n);
        repeat (n) begin
            @(negedge mclk);
            pkt_pop = 1'b1;
            @(negedge mclk);
            pkt_pop = 1'b0;
        end
        ticks(3);
    endtask : pop
    task automatic fwd(input logic [7:0] d);
        @(negedge mclk);
        {fwd_valid, fwd_data} = {1'b1, d};
        @(negedge mclk);
        fwd_valid = 1'b0;
        ticks(2500);
    endtask : fwd
    task automatic do_reset(input logic strap);
        @(negedge mclk);
        {reset, test_strap_n} = {1'b1, strap};
        ticks(12);
        reset = 1'b0;
        ticks(6);
    endtask : do_reset
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        void'($urandom(5));
        rf_rate_fast = 1'($urandom);
        do_reset(1'b1);
        foreach (RA[i]) rd(RA[i], RV[i]);
        wr(8'h50, 8'h33);
        rd(8'h50, 8'h00);
        wr(REG_BAUD, 8'h0a);
        wr(REG_GAP, 8'hff);
        wr(REG_PKT, 8'h04);
        wr(REG_CTS_ON, 8'h04);
        wr(REG_CTS_OFF, 8'h01);
        rd(REG_GAP, 8'hff);
        $display("test registers done");
        foreach (q[i]) q[i] = 8'($urandom);
        foreach (q[i]) host.send(q[i]);
        ticks(20);
        chk("pkt_done", 16'(n_done), 16'd1);
        chk("pkt_len", 16'(pkt_len), 16'd4);
        chk("cts_n full", 16'(cts_n), 16'd1);
        pop(2);
        chk("cts_n hold", 16'(cts_n), 16'd1);
        pop(2);
        chk("cts_n drained", 16'(cts_n), 16'd0);
        foreach (q[i]) chk("pkt_data", 16'(popq[i]), 16'(q[i]));
        $display("test size done");
        host.send(q[1]);
        host.send(q[2]);
        ticks(2200);
        chk("gap done", 16'(n_done), 16'd2);
        chk("gap len", 16'(pkt_len), 16'd2);
        pop(2);
        $display("test gap done");
        cmd_data_sel = 1'b0;
        ticks(4);
        chk("cmd_mode pin", 16'(cmd_mode), 16'd1);
        host.send(q[3]);
        host.send(q[0]);
        ticks(400);
        chk("cmd count", 16'(cmdq.size()), 16'd2);
        chk("cmd byte", 16'(cmdq[0]), 16'(q[3]));
        chk("no packet", 16'(n_done), 16'd2);
        cmd_data_sel = 1'b1;
        at_cmd_mode = 1'b1;
        ticks(4);
        chk("cmd_mode at", 16'(cmd_mode), 16'd1);
        at_cmd_mode = 1'b0;
        $display("test command done");
        rts_n = 1'b1;
        fwd(q[0]);
        chk("fwd free", 16'(host.got.size()), 16'd1);
        chk("fwd byte", 16'(host.got[0]), 16'(q[0]));
        rts_mode = 1'b1;
        fwd(q[1]);
        chk("rts held", 16'(host.got.size()), 16'd1);
        rts_n = 1'b0;
        ticks(2500);
        chk("rts resumed", 16'(host.got[1]), 16'(q[1]));
        {cmd_data_sel, rx_fwd_disable} = 2'b01;
        ticks(4);
        fwd(q[2]);
        chk("fwd dropped", 16'(host.got.size()), 16'd2);
        rx_fwd_disable = 1'b0;
        fwd(q[3]);
        chk("cmd fwd", 16'(host.got[2]), 16'(q[3]));
        $display("test forward done");
        for (int i = 0; i < 4; i++) begin
            {server_role, link_synced} = 2'(i);
            ticks(3);
            chk("in_range_n", 16'(in_range_n), 16'(i == 0));
        end
        $display("test range done");
        do_reset(1'b0);
        chk("test_mode", 16'(test_mode), 16'd1);
        test_strap_n = 1'b1;
        {fwd_valid, fwd_data} = {1'b1, 8'hff};
        ticks(1);
        fwd_valid = 1'b0;
        for (w = 0; w < 9000 && txd !== 1'b0; w++) @(negedge mclk);
        for (w = 0; w < 9000 && txd === 1'b0; w++) @(negedge mclk);
        chk("test bit", 16'(w >= start_cycles(9600) - 1 && w <= start_cycles(9600) + 1), 16'd1);
        chk("test stays", 16'(test_mode), 16'd1);
        do_reset(1'b1);
        chk("test left", 16'(test_mode), 16'd0);
        $display("test strap done");
        conclude();
    end
endmodule : hsl_frontend_tb
